// ==== core/phy_test_regs.vh ====
// Register map, field positions and timing constants of the PHY test and self-test control
`ifndef PHY_TEST_REGS_VH
`define PHY_TEST_REGS_VH
`define REG_BASIC_MODE_CONTROL     5'h00
`define REG_GIGABIT_CONTROL        5'h09
`define REG_AUXILIARY_CONTROL      5'h12
`define REG_EVENT_FLAGS            5'h14
`define REG_EVENT_ENABLES          5'h15
`define REG_EVENT_ACKNOWLEDGE      5'h17
`define REG_SELFTEST_COUNTER_VIEW  5'h18
`define REG_SELFTEST_CONFIG_PRI    5'h19
`define REG_SELFTEST_CONFIG_SEC    5'h1A
`define BMC_LOOPBACK               14
`define BMC_POWER_DOWN             11
`define BMC_ISOLATE                10
`define GIG_TEST_HI                15
`define GIG_TEST_LO                13
`define AUX_TEST_CLK_EN            6
`define AUX_SCOPE_EN               7
`define PRI_CNT_TYPE               15
`define PRI_CNT_CLEAR              14
`define PRI_LONG_PKT               13
`define PRI_LONG_GAP               12
`define PRI_TX_ENABLE              11
`define PRI_RANDOM                 10
`define SEC_CNT_ENABLE             15
`define SEC_CNT_UPPER              14
`define SEC_PKT_HI                 13
`define SEC_PKT_LO                 11
`define REG_RESET_VALUE            16'h0000
`define LONG_PKT_BYTES             16'h05EA
`define SHORT_PKT_BYTES            16'h003C
`define LONG_GAP_NS                9600
`define SHORT_GAP_NS               96
`define CLOCK_NS                   40
`define PRBS_SEED                  9'h1FF
`define MDIO_OP_WRITE              2'h1
`define MDIO_OP_READ               2'h2
`endif

// ==== core/phy_test_control.v ====
// PHY isolation, loopback, test modes, event output, power down and self-test logic
`timescale 1ns/1ns
`include "phy_test_regs.vh"

// Summary of operation
// (R1) Basic mode control bit 10 isolates the MAC interface.
// (R2) At 10/100 isolation ignores transmit inputs and floats all MII outputs.
// (R3) At gigabit isolation floats outputs, halts medium, and powers down.
// (R4) Basic mode control bit 14 loops MAC transmit onto receive, line silent.
// (R5) Looped data passes the coding and attachment path before turning back; here it turns back inside this block.
// (R6) Gigabit control bits 15:13 select test modes 1 to 4 or normal.
// (R7) Test modes drive pattern, test clock, start trigger and sync clock.
// (R8) Host enables test clock and scope outputs through auxiliary bits 6, 7.
// (R9) Reset leaves interrupt disabled and all event registers cleared.
// (R10) Interrupt is active low and holds until the status bit clears.
// (R11) Interrupt floats when nothing is enabled or nothing has occurred.
// (R12) Interrupt asserts when any flag and its matching enable are both one.
// (R13) Writing one to acknowledge clears a flag; acknowledge bit self-clears.
// (R14) Basic mode control bit 11 powers down all but management.
// (R15) Counter view shows upper or lower half of 32-bit counter by bit 14.
// (R16) Primary bit 15 selects error counter when one, packet counter when zero.
// (R17) Writing one to primary bit 14 clears the active receive counter.
// (R18) Receive counter counts only with secondary bit 15; traffic unaffected.
// (R19) Generator: bit 10 random/user, bit 13 1514/60 bytes, bit 12 long gap.
// (R20) User content sends primary bits 7:0 as every byte.
// (R21) Primary bit 11 starts the counted burst, cleared after last packet.
// (R22) Generating ignores MAC transmit; with loopback, packets go to receive.
// (R23) Count code 000 continuous, 001 one, each code ten times up to 110, 111 ten million.
// (R24) Gigabit self-test needs an active gigabit transmit clock from the MAC.
module phy_test_control #(
	parameter LONG_GAP_CYCLES = (`LONG_GAP_NS + `CLOCK_NS - 1) / `CLOCK_NS,
	parameter SHORT_GAP_CYCLES = (`SHORT_GAP_NS + `CLOCK_NS - 1) / `CLOCK_NS
) (
	// Clock and reset
	input  wire        mclk,
	input  wire        reset_n,
	// Management port
	input  wire        mgmt_req,
	input  wire [1:0]  mgmt_op,
	input  wire [4:0]  mgmt_addr,
	input  wire [15:0] mgmt_wdata,
	output reg  [15:0] mgmt_rdata,
	output reg         mgmt_ack,
	// Link state and events
	input  wire        speed_gig,
	input  wire [15:0] event_sources,
	input  wire        gtx_clk,
	// MAC transmit side
	input  wire [7:0]  mac_txd,
	input  wire        mac_tx_en,
	input  wire        mac_tx_er,
	// MAC receive side, from the line
	input  wire [7:0]  line_rxd,
	input  wire        line_rx_dv,
	input  wire        line_rx_er,
	// MAC outputs toward the MAC
	output reg  [7:0]  mac_rxd,
	output reg         mac_rx_dv,
	output reg         mac_rx_er,
	output reg         mac_outputs_oe,
	// Toward the coding path and line
	output reg  [7:0]  line_txd,
	output reg         line_tx_en,
	output reg         line_tx_er,
	output reg         medium_enable,
	output reg         power_down,
	output reg  [2:0]  test_mode,
	// Scope helper outputs
	output reg         pattern_test_clock,
	output reg         test_trigger,
	output reg         test_sync_clock,
	// Event output, open drain
	output reg         event_n_out,
	output reg         event_n_oe
);

////////////////////////////////////////////////////////////////////////////////
// Width of the gap counter; the long gap in core clocks must fit
localparam GAP_W = 16;

reg [15:0] bmc_q, gig_q, aux_q, flags_q, enables_q, pri_q, sec_q;
reg [31:0] rx_cnt_q;
reg [31:0] rx_err_q;
reg [2:0]  gtx_sync_q;
reg [23:0] pkt_left_q;
reg [15:0] byte_cnt_q;
reg [GAP_W-1:0] gap_cnt_q;
reg        gen_busy_q, in_gap_q;
reg [8:0]  prbs_q;
reg [3:0]  pat_div_q;
reg        rx_dv_q;

wire wr = mgmt_req & (mgmt_op == `MDIO_OP_WRITE);
wire isolate = bmc_q[`BMC_ISOLATE];
// Gigabit isolation doubles as power down
wire pdown = bmc_q[`BMC_POWER_DOWN] | (isolate & speed_gig);        // [R14] [R3]
wire loopback = bmc_q[`BMC_LOOPBACK];
wire tx_on = pri_q[`PRI_TX_ENABLE];
wire gtx_rise = gtx_sync_q[1] & ~gtx_sync_q[2];
// At gigabit the generator steps once per synchronised transmit clock rising edge
wire gen_step = tx_on & ~pdown & (~speed_gig | gtx_rise);          // [R24]
wire [15:0] pkt_len = pri_q[`PRI_LONG_PKT] ? `LONG_PKT_BYTES : `SHORT_PKT_BYTES; // [R19]
wire [GAP_W-1:0] gap_len = pri_q[`PRI_LONG_GAP] ? LONG_GAP_CYCLES[GAP_W-1:0] :
	SHORT_GAP_CYCLES[GAP_W-1:0];                                        // [R19]
wire [7:0] gen_byte = pri_q[`PRI_RANDOM] ? prbs_q[7:0] : pri_q[7:0]; // [R19] [R20]
wire gen_active = gen_busy_q & ~in_gap_q;
wire last_byte = gen_active & (byte_cnt_q == pkt_len - 16'h0001);
wire [2:0] pkt_code = sec_q[`SEC_PKT_HI:`SEC_PKT_LO];
// Active receive counter, of which the counter view shows one half
wire [31:0] rx_view = pri_q[`PRI_CNT_TYPE] ? rx_err_q : rx_cnt_q;      // [R16]
wire continuous = (pkt_code == 3'h0);                                  // [R23]
// Set wins over acknowledge: an event in the clearing cycle is kept
wire [15:0] flags_d = (flags_q & ~(wr && mgmt_addr == `REG_EVENT_ACKNOWLEDGE ?
	mgmt_wdata : 16'h0000)) | event_sources;                           // [R13]

// Packet count code to packet total
function [23:0] code_to_count;
	input [2:0] code;
	begin
		case (code)
			3'h1: code_to_count = 24'h000001;
			3'h2: code_to_count = 24'h00000A;
			3'h3: code_to_count = 24'h000064;
			3'h4: code_to_count = 24'h0003E8;
			3'h5: code_to_count = 24'h002710;
			3'h6: code_to_count = 24'h0186A0;
			3'h7: code_to_count = 24'h989680;
			default: code_to_count = 24'h000000;
		endcase
	end
endfunction                                                            // [R23]

////////////////////////////////////////////////////////////////////////////////
// Management registers
always @(posedge mclk) begin
	if (!reset_n) begin
		bmc_q     <= `REG_RESET_VALUE;
		gig_q     <= `REG_RESET_VALUE;
		aux_q     <= `REG_RESET_VALUE;
		flags_q   <= `REG_RESET_VALUE;                                    // [R9]
		enables_q <= `REG_RESET_VALUE;                                    // [R9]
		pri_q     <= `REG_RESET_VALUE;
		sec_q     <= `REG_RESET_VALUE;                                    // [R18]
	end else begin
		flags_q <= flags_d;                                                // [R13]
		// Counter clear is a one-cycle strobe
		pri_q[`PRI_CNT_CLEAR] <= 1'b0;
		// Event flags and counter view are read-only; writes there are ignored
		if (wr) begin
			if (mgmt_addr == `REG_BASIC_MODE_CONTROL) begin
				bmc_q <= mgmt_wdata;                                       // [R1]
			end else if (mgmt_addr == `REG_GIGABIT_CONTROL) begin
				gig_q <= mgmt_wdata;
			end else if (mgmt_addr == `REG_AUXILIARY_CONTROL) begin
				aux_q <= mgmt_wdata;
			end else if (mgmt_addr == `REG_EVENT_ENABLES) begin
				enables_q <= mgmt_wdata;
			end else if (mgmt_addr == `REG_SELFTEST_CONFIG_PRI) begin
				pri_q <= mgmt_wdata;
			end else if (mgmt_addr == `REG_SELFTEST_CONFIG_SEC) begin
				sec_q <= mgmt_wdata;
			end
		end
		// A host write in the same cycle takes precedence over the self-clear
		if (gen_step && last_byte && !continuous && pkt_left_q == 24'h000001 &&
			!(wr && mgmt_addr == `REG_SELFTEST_CONFIG_PRI))
			pri_q[`PRI_TX_ENABLE] <= 1'b0;                                 // [R21]
	end
end

// Read data and acknowledge
always @(posedge mclk) begin
	if (!reset_n) begin
		mgmt_rdata <= 16'h0000;
		mgmt_ack   <= 1'b0;
	end else begin
		// Acknowledge follows every request by one cycle, read or write
		mgmt_ack <= mgmt_req;
		if (mgmt_req && mgmt_op == `MDIO_OP_READ) begin
			if (mgmt_addr == `REG_BASIC_MODE_CONTROL)
				mgmt_rdata <= bmc_q;
			else if (mgmt_addr == `REG_GIGABIT_CONTROL)
				mgmt_rdata <= gig_q;
			else if (mgmt_addr == `REG_AUXILIARY_CONTROL)
				mgmt_rdata <= aux_q;
			else if (mgmt_addr == `REG_EVENT_FLAGS)
				mgmt_rdata <= flags_q;
			else if (mgmt_addr == `REG_EVENT_ENABLES)
				mgmt_rdata <= enables_q;
			else if (mgmt_addr == `REG_SELFTEST_COUNTER_VIEW)
				// Half chosen at read time; the other half is not latched
				mgmt_rdata <= sec_q[`SEC_CNT_UPPER] ? rx_view[31:16] : rx_view[15:0]; // [R15]
			else if (mgmt_addr == `REG_SELFTEST_CONFIG_PRI)
				mgmt_rdata <= pri_q;
			else if (mgmt_addr == `REG_SELFTEST_CONFIG_SEC)
				mgmt_rdata <= sec_q;
			else
				mgmt_rdata <= 16'h0000;
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// Receive self-test counters, observe only; only the active one counts
always @(posedge mclk) begin
	if (!reset_n) begin
		rx_cnt_q <= 32'h00000000;
		rx_err_q <= 32'h00000000;
		rx_dv_q  <= 1'b0;
	end else begin
		rx_dv_q <= line_rx_dv;
		// Packet counter: one count per rising edge of receive valid
		if (pri_q[`PRI_CNT_CLEAR] && !pri_q[`PRI_CNT_TYPE])
			rx_cnt_q <= 32'h00000000;                                      // [R17]
		else if (sec_q[`SEC_CNT_ENABLE] && !pri_q[`PRI_CNT_TYPE] &&      // [R18]
			line_rx_dv && !rx_dv_q)                                       // [R16]
			rx_cnt_q <= rx_cnt_q + 32'h00000001;
		// Error counter: one count per cycle with receive valid and error
		if (pri_q[`PRI_CNT_CLEAR] && pri_q[`PRI_CNT_TYPE])
			rx_err_q <= 32'h00000000;                                      // [R17]
		else if (sec_q[`SEC_CNT_ENABLE] && pri_q[`PRI_CNT_TYPE] &&       // [R18]
			line_rx_dv && line_rx_er)                                     // [R16]
			rx_err_q <= rx_err_q + 32'h00000001;
	end
end

////////////////////////////////////////////////////////////////////////////////
// Transmit packet generator
always @(posedge mclk) begin
	if (!reset_n) begin
		gtx_sync_q <= 3'h0;
		gen_busy_q <= 1'b0;
		in_gap_q   <= 1'b0;
		byte_cnt_q <= 16'h0000;
		gap_cnt_q  <= {GAP_W{1'b0}};
		pkt_left_q <= 24'h000000;
		prbs_q     <= `PRBS_SEED;
	end else begin
		// Two synchroniser stages, then one history stage for the edge
		gtx_sync_q <= {gtx_sync_q[1:0], gtx_clk};
		// Clearing the enable abandons the packet at once, continuous mode too
		if (!tx_on) begin
			gen_busy_q <= 1'b0;
			in_gap_q   <= 1'b0;
			byte_cnt_q <= 16'h0000;
		end else if (!gen_busy_q) begin
			// New burst: reload the packet total, restart the pseudo-random sequence
			gen_busy_q <= 1'b1;                                            // [R21]
			pkt_left_q <= code_to_count(pkt_code);
			prbs_q     <= `PRBS_SEED;
		end else if (in_gap_q) begin
			// Gap is counted in core clocks at every speed
			if (gap_cnt_q <= {{(GAP_W-1){1'b0}}, 1'b1})
				in_gap_q <= 1'b0;
			else
				gap_cnt_q <= gap_cnt_q - {{(GAP_W-1){1'b0}}, 1'b1};
		end else if (gen_step) begin
			prbs_q <= {prbs_q[7:0], prbs_q[8] ^ prbs_q[4]};
			if (last_byte) begin
				byte_cnt_q <= 16'h0000;
				in_gap_q   <= 1'b1;
				gap_cnt_q  <= gap_len;                                     // [R19]
				if (!continuous)
					pkt_left_q <= pkt_left_q - 24'h000001;
			end else
				byte_cnt_q <= byte_cnt_q + 16'h0001;
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// Data path steering
always @(posedge mclk) begin
	if (!reset_n) begin
		mac_rxd <= 8'h00;
		mac_rx_dv <= 1'b0;
		mac_rx_er <= 1'b0;
		mac_outputs_oe <= 1'b0;
		line_txd <= 8'h00;
		line_tx_en <= 1'b0;
		line_tx_er <= 1'b0;
		medium_enable <= 1'b0;
		power_down <= 1'b0;
	end else begin
		power_down <= pdown;                                               // [R14]
		medium_enable <= ~isolate & ~pdown;                                // [R2] [R3]
		mac_outputs_oe <= ~isolate & ~pdown;                               // [R2] [R3]
		// Generator owns the line path while enabled; MAC transmit is ignored
		if (tx_on) begin
			line_txd   <= gen_byte;                                        // [R22]
			line_tx_en <= gen_active;
			line_tx_er <= 1'b0;
		end else if (isolate) begin
			// Isolated: transmit inputs dropped, line held idle
			line_txd   <= 8'h00;                                           // [R2]
			line_tx_en <= 1'b0;
			line_tx_er <= 1'b0;
		end else begin
			line_txd   <= mac_txd;
			line_tx_en <= mac_tx_en;
			line_tx_er <= mac_tx_er;
		end
		if (loopback) begin
			// Looped data turns back inside this block without crossing the coding path; line only is muted
			line_tx_en <= 1'b0;                                            // [R4] [R5]
			mac_rxd    <= tx_on ? gen_byte : mac_txd;                      // [R4] [R22]
			mac_rx_dv  <= tx_on ? gen_active : mac_tx_en;
			mac_rx_er  <= tx_on ? 1'b0 : mac_tx_er;
		end else begin
			mac_rxd   <= line_rxd;
			mac_rx_dv <= line_rx_dv;
			mac_rx_er <= line_rx_er;
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// Test mode pattern clocks and event output
// Scope helpers come from a core clock divider and stay low in power down
// Event pin is open drain: data held low, the enable carries the assertion
always @(posedge mclk) begin
	if (!reset_n) begin
		test_mode <= 3'h0;
		pat_div_q <= 4'h0;
		pattern_test_clock <= 1'b0;
		test_trigger <= 1'b0;
		test_sync_clock <= 1'b0;
		event_n_out <= 1'b1;
		event_n_oe <= 1'b0;                                                // [R9]
	end else begin
		test_mode <= pdown ? 3'h0 : gig_q[`GIG_TEST_HI:`GIG_TEST_LO];      // [R6]
		pat_div_q <= (test_mode == 3'h0) ? 4'h0 : pat_div_q + 4'h1;
		pattern_test_clock <= (test_mode != 3'h0) & aux_q[`AUX_TEST_CLK_EN] &
			pat_div_q[0];                                                  // [R7] [R8]
		test_trigger <= (test_mode != 3'h0) & aux_q[`AUX_SCOPE_EN] &
			(pat_div_q == 4'h0);                                           // [R7] [R8]
		test_sync_clock <= (test_mode != 3'h0) & aux_q[`AUX_SCOPE_EN] &
			pat_div_q[3];                                                  // [R7] [R8]
		event_n_out <= 1'b0;                                               // [R10]
		event_n_oe  <= |(flags_d & enables_q);                             // [R10] [R11] [R12]
	end
end

endmodule // phy_test_control

// ==== testbench/phy_test_control_chk.sv ====
// Port checker for the PHY test control block
`timescale 1ns/1ns
module phy_test_control_chk (
	// Clock, reset and management
	input logic        mclk,
	input logic        reset_n,
	input logic        mgmt_req,
	input logic [1:0]  mgmt_op,
	input logic [4:0]  mgmt_addr,
	input logic [15:0] mgmt_wdata,
	input logic [15:0] mgmt_rdata,
	input logic        mgmt_ack,
	// Status and line side
	input logic        speed_gig,
	input logic        line_tx_en,
	input logic        mac_outputs_oe,
	input logic        medium_enable,
	input logic        power_down,
	input logic [2:0]  test_mode,
	input logic        pattern_test_clock,
	input logic        event_n_out,
	input logic        event_n_oe
);
	logic [15:0] bmc_q, gig_q, aux_q, en_q;
	// Shadow of the basic mode, gigabit, auxiliary and event enable registers
	always @(posedge mclk)
		if (!reset_n) {bmc_q, gig_q, aux_q, en_q} <= '0;
		else if (mgmt_req && mgmt_op == 2'h1) case (mgmt_addr)
			5'h00: bmc_q <= mgmt_wdata;
			5'h09: gig_q <= mgmt_wdata;
			5'h12: aux_q <= mgmt_wdata;
			5'h15: en_q <= mgmt_wdata;
			default: ;
		endcase
	////////////////////////////////////////
	default clocking @(posedge mclk); endclocking
	default disable iff (!reset_n);
	property p_ack; mgmt_req |=> mgmt_ack; endproperty
	property p_iso; bmc_q[10] [*3] |-> !mac_outputs_oe && !medium_enable; endproperty
	property p_giso; (speed_gig && bmc_q[10]) [*3] |-> power_down; endproperty
	property p_pd; bmc_q[11] [*3] |-> power_down; endproperty
	property p_loop; bmc_q[14] [*3] |-> !line_tx_en; endproperty
	property p_pol; event_n_oe |-> !event_n_out; endproperty
	property p_float; (en_q == 16'h0000) [*3] |-> !event_n_oe; endproperty
	property p_tm;
		(!bmc_q[11] && !bmc_q[10] && $stable(gig_q)) [*3] |-> test_mode == gig_q[15:13];
	endproperty
	property p_scope; !aux_q[6] [*3] |-> !pattern_test_clock; endproperty
	property p_ackrd;
		mgmt_req && mgmt_op == 2'h2 && mgmt_addr == 5'h17 |=> mgmt_rdata == 16'h0000;
	endproperty
	a_ack: assert property (p_ack) else $error("no ack");
	a_iso: assert property (p_iso) else $error("isolate");
	a_giso: assert property (p_giso) else $error("gig isolate");
	a_pd: assert property (p_pd) else $error("power down");
	a_loop: assert property (p_loop) else $error("loopback line");
	a_pol: assert property (p_pol) else $error("event level");
	a_float: assert property (p_float) else $error("event float");
	a_tm: assert property (p_tm) else $error("test mode");
	a_scope: assert property (p_scope) else $error("test clock");
	a_ackrd: assert property (p_ackrd) else $error("ack read");
	c_evt: cover property (event_n_oe);
	c_pd: cover property (power_down);
	c_tm4: cover property (test_mode == 3'h4);
endmodule // phy_test_control_chk
bind phy_test_control phy_test_control_chk u_chk (.*);

// ==== testbench/mac_partner.sv ====
// MAC side model: gigabit transmit clock and transmit frames
`timescale 1ns/1ns
module mac_partner (
	// Control from the bench
	input  logic       mclk,
	input  logic       gtx_on,
	input  logic       start,
	input  logic [7:0] len,
	input  logic [7:0] seed,
	// MAC transmit pins
	output logic       gtx_clk,
	output logic [7:0] mac_txd,
	output logic       mac_tx_en,
	output logic       mac_tx_er
);
	logic [7:0] left_q;
	assign mac_tx_er = 1'b0;
	initial begin
		{left_q, mac_txd, mac_tx_en, gtx_clk} = '0;
		forever #160 gtx_clk = gtx_on & ~gtx_clk;
	end
	// Whole frame of len bytes; data toggles while idle
	always @(posedge mclk)
		if (start) begin
			left_q <= len;
			mac_txd <= seed;
			mac_tx_en <= 1'b1;
		end else if (left_q > 8'h01) begin
			left_q <= left_q - 8'h01;
			mac_txd <= mac_txd + 8'h01;
		end else begin
			left_q <= 8'h00;
			mac_tx_en <= 1'b0;
			mac_txd <= ~mac_txd;
		end
endmodule // mac_partner

// ==== testbench/phy_test_control_bench.sv ====
// Self-checking bench for the PHY test control block
`timescale 1ns/1ns
module phy_test_control_bench;
	logic        mclk = 0, reset_n = 0, mgmt_req = 0, speed_gig = 0, line_rx_dv = 0;
	logic        line_rx_er = 0, gtx_on = 0, start = 0, byte_chk = 0, ptc_seen = 0;
	logic [1:0]  sc_seen = 0;
	logic [1:0]  mgmt_op = 0;
	logic [4:0]  mgmt_addr = 0;
	logic [15:0] mgmt_wdata = 0, event_sources = 0, mgmt_rdata;
	logic [7:0]  line_rxd = 0, pseed = 0, mac_txd, mac_rxd, line_txd, ub;
	logic        gtx_clk, mac_tx_en, mac_tx_er, mgmt_ack, mac_rx_dv, mac_rx_er, line_tx_en;
	logic        mac_outputs_oe, line_tx_er, medium_enable, power_down, pattern_test_clock;
	logic        test_trigger, test_sync_clock, event_n_out, event_n_oe;
	logic [2:0]  test_mode;
	logic [16:0] rq[$];
	logic [7:0]  lq[$];
	logic [4:0]  ra[10] = '{5'h00, 5'h09, 5'h12, 5'h14, 5'h15, 5'h17, 5'h18, 5'h19, 5'h1A, 5'h05};
	int          seed = 32'h920b, mismatches = 0, cmp_count = 0, cyc = 0;
	int          nbytes = 0, idle = 0, gap = 0, i, k, n;
	phy_test_control #(.LONG_GAP_CYCLES(20), .SHORT_GAP_CYCLES(3)) u_dut (.*);
	mac_partner u_mac (.mclk(mclk), .gtx_on(gtx_on), .start(start), .len(8'h08),
		.seed(pseed), .gtx_clk(gtx_clk), .mac_txd(mac_txd), .mac_tx_en(mac_tx_en),
		.mac_tx_er(mac_tx_er));
	initial forever #20 mclk = ~mclk;
	////////////////////////////////////////
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		cmp_count++;
		if (g !== e) begin
			mismatches++;
			$display("mismatch at %0t: got %h exp %h", $time, g, e);
		end
	endtask
	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task automatic tick(input int c);
		repeat (c) @(posedge mclk);
	endtask
	task automatic req(input logic [1:0] op, input logic [4:0] a, input logic [15:0] d,
			input logic [16:0] e);
		rq.push_back(e);
		mgmt_req <= 1'b1;
		mgmt_op <= op;
		mgmt_addr <= a;
		mgmt_wdata <= d;
		tick(1);
		mgmt_req <= 1'b0;
		tick(1);
	endtask
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		req(2'h1, a, d, 17'h00000);
	endtask
	task automatic rd(input logic [4:0] a, input logic [15:0] e);
		req(2'h2, a, 16'($random(seed)), {1'b1, e});
	endtask
	task automatic frames(input int c, input logic er);
		repeat (c) begin
			line_rx_dv <= 1'b1;
			line_rx_er <= er;
			line_rxd <= 8'($random(seed));
			tick(3);
			line_rx_dv <= 1'b0;
			line_rx_er <= 1'b0;
			tick(2);
		end
	endtask
	task automatic gen(input logic [15:0] pri, input logic [15:0] sec, input int tgt);
		ub = 8'($random(seed));
		byte_chk = !pri[10];
		nbytes = 0;
		wr(5'h1A, sec);
		wr(5'h19, pri | ub);
		start <= 1'b1;
		tick(1);
		start <= 1'b0;
		for (k = 0; k < 4000 && nbytes < tgt; k++) tick(1);
		tick(40);
		rd(5'h19, (pri | ub) & 16'hF7FF);
		chk(nbytes, tgt);
	endtask
	////////////////////////////////////////
	always @(negedge mclk) begin
		if (mgmt_ack) begin
			if (rq[0][16]) chk(mgmt_rdata, rq[0][15:0]);
			void'(rq.pop_front());
		end
		if (mac_rx_dv && lq.size() > 0) chk({mac_rx_er, mac_rxd}, {1'b0, lq.pop_front()});
		ptc_seen = ptc_seen | pattern_test_clock;
		sc_seen = sc_seen | {test_trigger, test_sync_clock};
		if (line_tx_en) begin
			if (idle > 0) gap = idle;
			idle = 0;
			nbytes++;
			if (byte_chk) chk({line_tx_er, line_txd}, {1'b0, ub});
		end else idle++;
	end
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 40000) begin
			mismatches++;
			finish_test();
		end
	end
	initial begin
		tick(5);
		reset_n <= 1'b1;
		tick(1);
		wr(5'h14, 16'hFFFF);
		for (i = 0; i < 10; i++) rd(ra[i], 16'h0000);
		for (i = 1; i < 5; i += 3) begin
			n = $random(seed);
			wr(ra[i], 16'(n));
			rd(ra[i], 16'(n));
		end
		wr(5'h15, 16'h0000);
		k = $random(seed) & 15;
		event_sources <= 16'h0001 << k;
		tick(2);
		chk(event_n_oe, 0);
		wr(5'h15, 16'h0001 << k);
		event_sources <= 16'h0000;
		tick(3);
		chk({event_n_oe, event_n_out}, 2'b10);
		rd(5'h14, 16'h0001 << k);
		wr(5'h15, 16'h0000);
		tick(2);
		chk(event_n_oe, 0);
		wr(5'h15, 16'h0001 << k);
		tick(2);
		chk(event_n_oe, 1);
		wr(5'h17, 16'h0001 << k);
		tick(2);
		chk(event_n_oe, 0);
		rd(5'h14, 16'h0000);
		wr(5'h12, 16'h00C0);
		for (i = 0; i < 5; i++) begin
			wr(5'h09, 16'(i << 13));
			tick(4);
			ptc_seen = 1'b0;
			sc_seen = 2'b00;
			tick(36);
			chk(test_mode, i);
			chk(ptc_seen, i != 0);
			chk(sc_seen, (i != 0) ? 2'b11 : 2'b00);
		end
		wr(5'h09, 16'h0000);
		wr(5'h00, 16'h0400);
		tick(4);
		chk(mac_outputs_oe, 0);
		rd(5'h00, 16'h0400);
		gtx_on <= 1'b1;
		speed_gig <= 1'b1;
		tick(6);
		chk(power_down, 1);
		speed_gig <= 1'b0;
		gtx_on <= 1'b0;
		wr(5'h00, 16'h0800);
		tick(4);
		chk(power_down, 1);
		wr(5'h00, 16'h4000);
		pseed <= 8'($random(seed));
		tick(4);
		chk({power_down, mac_outputs_oe}, 2'b01);
		for (i = 0; i < 8; i++) lq.push_back(8'(pseed + i));
		start <= 1'b1;
		tick(1);
		start <= 1'b0;
		tick(30);
		chk(lq.size(), 0);
		wr(5'h00, 16'h0000);
		gen(16'h0800, 16'h0800, 60);
		gen(16'h2800, 16'h0800, 1514);
		gen(16'h1800, 16'h1000, 600);
		chk(gap, 20);
		gen(16'h0C00, 16'h0800, 60);
		wr(5'h1A, 16'h0000);
		nbytes = 0;
		wr(5'h19, 16'h0855);
		tick(300);
		wr(5'h19, 16'h0055);
		tick(100);
		n = nbytes;
		tick(100);
		chk(n > 120 && nbytes == n, 1);
		frames(2, 1'b0);
		rd(5'h18, 16'h0000);
		wr(5'h1A, 16'h8000);
		n = 1 + ($random(seed) & 3);
		frames(n, 1'b0);
		rd(5'h18, 16'(n));
		wr(5'h1A, 16'hC000);
		rd(5'h18, 16'h0000);
		wr(5'h19, 16'h8000);
		wr(5'h1A, 16'h8000);
		frames(2, 1'b1);
		rd(5'h18, 16'h0006);
		wr(5'h19, 16'hC000);
		tick(2);
		rd(5'h18, 16'h0000);
		finish_test();
	end
endmodule // phy_test_control_bench
